// file: common/irq_logic_regs.svh
// register offsets, field positions and reset values of the interrupt logic
`ifndef IRQ_LOGIC_REGS_SVH
`define IRQ_LOGIC_REGS_SVH
`define FLAGS_ADDR 8'h02
`define CONFIG_ADDR 8'h53
`define CFG_POL_BIT 7
`define BIT_BROKEN 6
`define BIT_POORQ 5
`define BIT_XFER 4
`define BIT_PIN 3
`define BIT_LERR 2
`define BIT_WAKE 1
`define FLAGS_CLR_ALL 8'h7F
`define FLAGS_USED_MASK 8'h7E
`define CONFIG_WR_MASK 8'hFE
`define FLAGS_RESET 8'h00
`define CONFIG_RESET 8'h00
`define LINK_QUALITY_VALUE_MAX 8'hFF
`endif

// file: common/irq_logic_pkg.sv
// types shared by the interrupt logic
package irq_logic_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		ROLE_TX = 2'b01,
		ROLE_RX = 2'b10
	} role_e;
endpackage

// file: hw/wireless_audio_irq_logic.sv
// interrupt flags, configuration and interrupt pin of the audio link device
// How it works
// - config bit 7 picks pin polarity: 0 active low, 1 active high
// - pin stays active until host writes one to the matching flag bit or reads the flag register
// - writing 0x7F to the flag register clears every flag
// - reading the flag register clears it and drops the interrupt
// - flag bit 6 marks broken link, config bit 6 enables it
// - flag bit 5 set when quality at or below warning threshold
// - flag bit 4 set when a remote command transfer completes
// - flag bit 3 marks change on remote inputs or own outputs
// - config bit 2 enables the link error interrupt
// - flag bit 1 marks wakeup from power down, config bit 1 enables
// - pin always present as transmitter, as receiver only with slave port
// - each device keeps its own flags and drives only its own pin
// - wakeup interrupt enabled masks every other source from the pin
// - in wakeup mode pin is active when powered up, idle in power down
// - poor quality and transfer done only raised in transmitter role
// - link quality is 255 minus packets lost in the fourteen-frame window
`timescale 1ns/10ps
`default_nettype none
`include "irq_logic_regs.svh"

module wireless_audio_irq_logic (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// role and host interface presence
	input wire irq_logic_pkg::role_e role_i,
	input wire logic slave_if_en_i,
	// register port from the serial slave interface
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// event sources
	input wire logic link_broken_i,
	input wire logic [7:0] packets_lost_i,
	input wire logic quality_update_i,
	input wire logic [7:0] link_warning_threshold_i,
	input wire logic link_error_i,
	input wire logic remote_done_i,
	input wire logic [3:0] remote_input_pins_i,
	input wire logic [3:0] receiver_pin_io_i,
	input wire logic wakeup_i,
	input wire logic powered_up_i,
	// link quality and interrupt pin
	output logic [7:0] link_quality_value_o,
	output logic irq_o,
	output logic irq_oe_o
);
	import irq_logic_pkg::*;

	byte_t flags_q;
	byte_t config_q;
	byte_t flags_set;
	byte_t flags_clr;
	byte_t pending;
	logic [3:0] pins_q;
	logic pins_valid_q;
	logic [3:0] pins_now;
	logic is_tx;
	logic pin_present;
	logic irq_active;
	logic flags_rd;
	logic flags_wr;

	assign is_tx = (role_i == ROLE_TX);
	assign flags_rd = reg_rd_i && (reg_addr_i == `FLAGS_ADDR);
	assign flags_wr = reg_wr_i && (reg_addr_i == `FLAGS_ADDR);
	assign pins_now = is_tx ? remote_input_pins_i : receiver_pin_io_i;

	// link quality from loss count
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			link_quality_value_o <= `LINK_QUALITY_VALUE_MAX;
		end else if (quality_update_i) begin
			link_quality_value_o <= `LINK_QUALITY_VALUE_MAX - packets_lost_i;
		end
	end

	// previous pin levels for change detection
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pins_q <= 4'h0;
			pins_valid_q <= 1'b0;
		end else begin
			pins_q <= pins_now;
			pins_valid_q <= 1'b1;
		end
	end

	// event detection into flag set vector
	always_comb begin
		flags_set = 8'h00;
		flags_set[`BIT_BROKEN] = link_broken_i;
		flags_set[`BIT_POORQ] = is_tx && quality_update_i &&
			((`LINK_QUALITY_VALUE_MAX - packets_lost_i) <= link_warning_threshold_i);
		flags_set[`BIT_XFER] = is_tx && remote_done_i;
		flags_set[`BIT_PIN] = pins_valid_q && (pins_now != pins_q);
		flags_set[`BIT_LERR] = link_error_i;
		flags_set[`BIT_WAKE] = wakeup_i;
	end

	// host clears: write-one, clear-all code, or read
	always_comb begin
		flags_clr = 8'h00;
		if (flags_rd) begin
			flags_clr = 8'hFF;
		end else if (flags_wr) begin
			flags_clr = (reg_wdata_i == `FLAGS_CLR_ALL) ? 8'hFF : reg_wdata_i;
		end
	end

	// flag register, set wins over clear
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			flags_q <= `FLAGS_RESET;
		end else begin
			flags_q <= ((flags_q & ~flags_clr) | flags_set) & `FLAGS_USED_MASK;
		end
	end

	// configuration register
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			config_q <= `CONFIG_RESET;
		end else if (reg_wr_i && (reg_addr_i == `CONFIG_ADDR)) begin
			config_q <= reg_wdata_i & `CONFIG_WR_MASK;
		end
	end

	// read data mux
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`FLAGS_ADDR: reg_rdata_o <= flags_q;
				`CONFIG_ADDR: reg_rdata_o <= config_q;
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// interrupt decision
	always_comb begin
		pending = flags_q & config_q & `FLAGS_USED_MASK;
		if (config_q[`BIT_WAKE]) begin
			irq_active = powered_up_i;
		end else begin
			irq_active = |pending;
		end
	end

	assign pin_present = is_tx || slave_if_en_i;

	// pin driver with polarity
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			irq_o <= 1'b1;
			irq_oe_o <= 1'b0;
		end else begin
			irq_o <= irq_active ~^ config_q[`CFG_POL_BIT];
			irq_oe_o <= pin_present;
		end
	end
endmodule
`default_nettype wire

// file: tb/mcu.sv
// host model on the register port
`timescale 1ns/10ps
`default_nettype none
module mcu (
	// clock and register port
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o, wdata_o,
	output logic wr_o, rd_o
);
	initial {addr_o, wdata_o, wr_o, rd_o} = '0;
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(posedge clk_i) #1;
		{addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
		@(posedge clk_i) #1;
		{addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00}; // released address and data lines flip, strobes drop
		q = rdata_i;
	endtask
endmodule
`default_nettype wire

// file: tb/irq_logic_props.sv
// port checks of the interrupt logic
`timescale 1ns/10ps
`default_nettype none
module irq_logic_props (
	// watched ports
	input wire logic core_clk_i, srst_i, slave_if_en_i, reg_rd_i, link_broken_i,
	input wire logic quality_update_i, irq_oe_o,
	input wire logic [7:0] reg_addr_i, reg_rdata_o, packets_lost_i, link_quality_value_o,
	input wire irq_logic_pkg::role_e role_i
);
	import irq_logic_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	a_oe_tx: assert property (role_i == ROLE_TX |=> irq_oe_o) else $error("oe tx");
	a_oe_absent: assert property (role_i == ROLE_RX && !slave_if_en_i |=> !irq_oe_o)
		else $error("oe rx");
	a_oe_slave: assert property (role_i == ROLE_RX && slave_if_en_i |=> irq_oe_o)
		else $error("oe slave");
	a_qual_load: assert property (quality_update_i |=>
		link_quality_value_o == 8'hFF - $past(packets_lost_i)) else $error("quality");
	a_qual_hold: assert property (!quality_update_i |=> $stable(link_quality_value_o))
		else $error("quality hold");
	a_broken_flag: assert property (link_broken_i ##1 (reg_rd_i && reg_addr_i == 8'h02)
		|=> reg_rdata_o[6]) else $error("broken flag");
	a_rsvd_bits: assert property (reg_rd_i && reg_addr_i == 8'h02 |=>
		!reg_rdata_o[7] && !reg_rdata_o[0]) else $error("reserved bits");
	a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata");
	c_read: cover property (reg_rd_i && reg_addr_i == 8'h02);
	c_qual: cover property (quality_update_i);
	c_rx: cover property (role_i == ROLE_RX);
endmodule
bind wireless_audio_irq_logic irq_logic_props u_irq_logic_props (.core_clk_i, .srst_i,
	.slave_if_en_i, .reg_rd_i, .link_broken_i, .quality_update_i, .irq_oe_o, .reg_addr_i,
	.reg_rdata_o, .packets_lost_i, .link_quality_value_o, .role_i);
`default_nettype wire

// file: tb/wireless_audio_irq_logic_tb_top.sv
// self-checking bench of the interrupt logic
`timescale 1ns/10ps
`default_nettype none
module wireless_audio_irq_logic_tb_top;
	import irq_logic_pkg::*;
	logic core_clk_i = 0, srst_i = 1, pw = 1, sl = 0, wr, rd, irq, oe;
	logic [6:0] ev = 0;
	logic [3:0] pt = 0, pr = 0;
	logic [7:0] lost = 0, thr = 0, ad, wd, rdat, lq, q;
	role_e role = ROLE_TX;
	int fails = 0, n_compared = 0;
	always #10 core_clk_i = ~core_clk_i;
	wireless_audio_irq_logic u_wireless_audio_irq_logic (.core_clk_i, .srst_i, .role_i(role),
		.slave_if_en_i(sl), .reg_addr_i(ad), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd),
		.reg_rdata_o(rdat), .link_broken_i(ev[6]), .packets_lost_i(lost),
		.quality_update_i(ev[5]), .link_warning_threshold_i(thr), .link_error_i(ev[2]),
		.remote_done_i(ev[4]), .remote_input_pins_i(pt), .receiver_pin_io_i(pr),
		.wakeup_i(ev[1]), .powered_up_i(pw), .link_quality_value_o(lq), .irq_o(irq),
		.irq_oe_o(oe));
	mcu u_mcu (.clk_i(core_clk_i), .rdata_i(rdat), .addr_o(ad), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
	function automatic logic [7:0] qv(input logic [7:0] n);
		return 8'hFF - n;
	endfunction
	task automatic chk(input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			$display("BAD %0t got %h want %h", $time, s, e);
			fails++;
		end
	endtask
	task automatic fire(input int i);
		@(posedge core_clk_i) #1;
		if (i == 3) pt = ~pt; else ev[i] = 1;
		@(posedge core_clk_i) #1;
		ev = 0;
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask
	task wrap_up;
		$display("fails %0d compared %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		fails++;
		wrap_up;
	end
	// main sequence
	initial begin
		void'($urandom(30796));
		repeat (2) @(posedge core_clk_i);
		#1 srst_i = 0;
		lost = $urandom;
		thr = qv(lost); // quality lands exactly on the threshold
		u_mcu.acc(1, 8'h02, 8'h7F, q);
		u_mcu.acc(1, 8'h53, 8'h7C, q);
		for (int i = 6; i > 0; i--) begin
			fire(i);
			chk(irq, i == 1);
			u_mcu.acc(0, 8'h02, 0, q);
			chk(q, 8'h01 << i);
			@(posedge core_clk_i) #1;
			chk(irq, 1);
		end
		chk(lq, qv(lost));
		u_mcu.acc(1, 8'h53, 8'hC0, q);
		fire(6);
		chk(irq, 1);
		u_mcu.acc(1, 8'h02, 8'h40, q);
		@(posedge core_clk_i) #1;
		chk(irq, 0);
		fire(6);
		fire(2);
		u_mcu.acc(1, 8'h02, 8'h7F, q);
		u_mcu.acc(0, 8'h02, 0, q);
		chk(q, 0);
		role = ROLE_RX;
		u_mcu.acc(0, 8'h02, 0, q);
		fire(4);
		fire(5);
		pr = ~pr;
		u_mcu.acc(0, 8'h02, 0, q);
		chk(q, 8'h08);
		chk(oe, 0);
		sl = 1;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk(oe, 1);
		sl = 0;
		role = ROLE_TX;
		u_mcu.acc(1, 8'h53, 8'hC2, q);
		pw = 0;
		fire(6);
		chk(irq, 0);
		pw = 1;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk(irq, 1);
		// broken link event right before a read, flag must show at once
		ev[6] = 1;
		u_mcu.acc(0, 8'h02, 0, q);
		ev = 0;
		chk(q & 8'h40, 8'h40);
		u_mcu.acc(0, 8'h10, 0, q);
		chk(q, 0);
		wrap_up;
	end
endmodule
`default_nettype wire
